// ### pdbist_pkg.sv
// constants, register map and types for the pd mac self-test control block
package pdbist_pkg;
   // register byte addresses
   localparam logic [15:0] PDBIST_CTRL_A_ADDR = 16'h1AC0;
   localparam logic [15:0] PDBIST_CTRL_B_ADDR = 16'h1AC1;
   localparam logic [15:0] PDBIST_ERR_HI_ADDR = 16'h1AC2;
   localparam logic [15:0] PDBIST_ERR_LO_ADDR = 16'h1AC3;
   localparam logic [15:0] PDBIST_RX_STAT_ADDR = 16'h1AC7;
   // self_test_control_a fields
   localparam int PDBIST_RX_EN_BIT = 4;
   localparam int PDBIST_EN_BIT = 3;
   localparam int PDBIST_MODE_MSB = 2;
   localparam logic [2:0] PDBIST_MODE_RESET = 3'h0;
   localparam logic [2:0] PDBIST_MODE_CARRIER2 = 3'h2;
   // self_test_control_b fields
   localparam int PDBIST_CLR_BIT = 2;
   localparam int PDBIST_TXRST_BIT = 1;
   localparam int PDBIST_START_BIT = 0;
   // receive status fields
   localparam int PDBIST_RX_DONE_BIT = 0;
   localparam int PDBIST_RX_ERR_BIT = 1;
   // reset values
   localparam logic [7:0] PDBIST_BYTE_RESET = 8'h00;
   localparam logic [15:0] PDBIST_COUNT_RESET = 16'h0000;
   // bit timing: core clock and nominal line rate
   localparam int PDBIST_CLK_MHZ = 200;
   localparam int PDBIST_BIT_RATE_KBPS = 300;
   localparam int PDBIST_BIT_CYCLES = (PDBIST_CLK_MHZ * 1000) / PDBIST_BIT_RATE_KBPS;
   localparam int PDBIST_BIT_CNT_W = 10;
   localparam logic [PDBIST_BIT_CNT_W-1:0] PDBIST_BIT_LAST =
      PDBIST_BIT_CNT_W'(PDBIST_BIT_CYCLES - 1);
   // prbs test frame: bit counter width and last bit index, 1024 bits per frame
   localparam int PDBIST_FRAME_W = 11;
   localparam logic [PDBIST_FRAME_W-1:0] PDBIST_FRAME_LAST = 11'h3FF;
   // prbs generator shape
   localparam int PDBIST_PRBS_W = 15;
   localparam logic [PDBIST_PRBS_W-1:0] PDBIST_PRBS_SEED = 15'h7FFF;
   localparam int PDBIST_ERR_W = 16;
   localparam logic [PDBIST_ERR_W-1:0] PDBIST_ERR_MAX = 16'hFFFF;
   // test transmitter states
   typedef enum logic [1:0] {
      PDBIST_TX_IDLE = 2'b00,
      PDBIST_TX_CARRIER = 2'b01,
      PDBIST_TX_FRAME = 2'b10
   } pdbist_tx_state_t;
endpackage : pdbist_pkg

// ### pdbist_prbs.sv
// prbs generator, used both for sending and for checking test frames
`timescale 1ns/1ps
module pdbist_prbs
   import pdbist_pkg::*;
(
   input wire logic i_clk, // core clock
   input wire logic i_sys_rst, // async reset, active high
   input wire logic i_load, // reload the seed
   input wire logic i_step, // advance one bit
   output logic o_bit // current sequence bit
);
   logic [PDBIST_PRBS_W-1:0] lfsr;

   // load wins over step so a reset and a bit never mix
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         lfsr <= PDBIST_PRBS_SEED;
      end else if (i_load) begin
         lfsr <= PDBIST_PRBS_SEED;
      end else if (i_step) begin
         lfsr <= {lfsr[PDBIST_PRBS_W-2:0], lfsr[14] ^ lfsr[13]};
      end
   end

   assign o_bit = lfsr[PDBIST_PRBS_W-1];
endmodule : pdbist_prbs

// ### pdbist_err_count.sv
// saturating sixteen bit test error counter
`timescale 1ns/1ps
module pdbist_err_count
   import pdbist_pkg::*;
(
   input wire logic i_clk, // core clock
   input wire logic i_sys_rst, // async reset, active high
   input wire logic i_clear, // zero the count
   input wire logic i_inc, // one error seen
   output logic [PDBIST_ERR_W-1:0] o_count // current count
);
   // clear wins: a clear is a command, a stray error in the same cycle is lost
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_count <= PDBIST_COUNT_RESET;
      end else if (i_clear) begin
         o_count <= PDBIST_COUNT_RESET;
      end else if (i_inc && (o_count != PDBIST_ERR_MAX)) begin
         o_count <= o_count + 16'h0001; // saturate rather than wrap
      end
   end
endmodule : pdbist_err_count

// ### pdbist_ctrl.sv
// self-test control for the pd mac: registers, test transmitter, receive checker
//
// Functional notes
// [RULE_01] Software clears then sets receive enable for every new test receive request.
// [RULE_02] In loopback, software starts every test packet itself.
// [RULE_03] Self-test enable plus loopback keeps received data out of the functional path.
// [RULE_04] With loopback in self-test mode, hard reset signalling is not detected.
// [RULE_05] Self-test enable powers the biphase-mark transmitter; clearing removes that power.
// [RULE_06] Software holds self-test enable at least 5us before starting a frame.
// [RULE_07] Three-bit pattern mode resets to zero; only 010b carrier mode is supported.
// [RULE_08] Software never programs a reserved pattern mode value.
// [RULE_09] Writing one to control b bit 2 zeroes the whole error counter.
// [RULE_10] Writing one to control b bit 1 resets transmit logic and its prbs.
// [RULE_11] Software pulses transmit reset once before first start, not again mid-test.
// [RULE_12] Transmit reset is a pulse, never stored, always reads zero.
// [RULE_13] Starting a frame never reloads the prbs; the sequence runs on.
// [RULE_14] Transmit reset stops continuous sending; idle within one bit time.
// [RULE_15] Software waits one bit time after transmit reset before clearing enable.
// [RULE_16] Reset and start in one write: reset acts, start is dropped.
// [RULE_17] Writing one to control b bit 0 starts a test frame.
// [RULE_18] Reading control b bit 0 returns transmission busy, not the written value.
// [RULE_19] Carrier mode sends until transmit reset; otherwise one prbs frame.
// [RULE_20] No following frame is sent by itself; software restarts each one.
// [RULE_21] Test receive with auto response on sends the error count message.
// [RULE_22] The high count register shows counter bits 15 to 8, reset zero.
// [RULE_23] Setting receive enable bit 4 enables receiver, reloads checker, clears count.
// [RULE_24] The low count register shows counter bits 7 to 0.
// [RULE_25] A received frame sets a write-one-clear done flag and error flag bit 1.
// [RULE_26] Each received bit unlike the expected prbs bit adds one error.
`timescale 1ns/1ps
module pdbist_ctrl
   import pdbist_pkg::*;
(
   input wire logic i_clk, // core clock, 200 MHz
   input wire logic i_sys_rst, // async reset, active high
   input wire logic [15:0] i_addr, // register byte address
   input wire logic [7:0] i_wdata, // register write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [7:0] o_rdata, // read data, cycle after i_rd
   input wire logic i_loopback_enable, // receive loopback enable
   input wire logic i_automatic_response_enable, // auto response mode
   input wire logic i_rx_bit, // decoded receive bit
   input wire logic i_rx_bit_valid, // one pulse per decoded bit
   input wire logic i_rx_frame_end, // end of received test frame
   input wire logic i_rx_data_valid, // receive data toward functional path
   input wire logic i_hard_reset_seen, // hard reset signalling decoded
   output logic o_functional_rx_valid, // receive data passed to functional path
   output logic o_hard_reset_detected, // hard reset reported onward
   output logic o_tx_power_up, // biphase-mark transmitter test power
   output logic o_tx_active, // test transmitter sending
   output logic o_tx_bit, // test bit to the encoder
   output logic o_tx_bit_strobe, // pulse: new test bit on o_tx_bit
   output logic o_send_error_count_msg // pulse: send error count message
);
   // register state
   logic test_receive_enable;
   logic self_test_enable;
   logic [2:0] test_pattern_mode;
   logic test_frame_received_flag;
   logic test_frame_error_flag;
   logic frame_had_error;

   // decoded accesses
   logic wr_ctrl_a;
   logic wr_ctrl_b;
   logic wr_rx_stat;
   logic tx_reset_pulse;
   logic tx_start_pulse;
   logic clear_count_pulse;
   logic rx_enable_rise;
   logic rx_bit_take;
   logic rx_mismatch;
   logic rx_frame_done;

   // transmitter state
   pdbist_tx_state_t tx_state;
   pdbist_tx_state_t next_tx_state;
   logic [PDBIST_BIT_CNT_W-1:0] bit_timer;
   logic [PDBIST_FRAME_W-1:0] frame_bits;
   logic bit_end;
   logic tx_prbs_bit;
   logic tx_prbs_step;
   logic chk_prbs_bit;
   logic [PDBIST_ERR_W-1:0] test_error_count;
   logic [7:0] next_rdata;

   // write decode; every strobe is a single cycle
   assign wr_ctrl_a = i_wr && (i_addr == PDBIST_CTRL_A_ADDR);
   assign wr_ctrl_b = i_wr && (i_addr == PDBIST_CTRL_B_ADDR);
   assign wr_rx_stat = i_wr && (i_addr == PDBIST_RX_STAT_ADDR);

   // control b bits act as pulses and are never held
   assign tx_reset_pulse = wr_ctrl_b && i_wdata[PDBIST_TXRST_BIT]; // RULE_10 RULE_12
   assign clear_count_pulse = wr_ctrl_b && i_wdata[PDBIST_CLR_BIT]; // RULE_09
   // a start written beside a reset is simply dropped
   assign tx_start_pulse = wr_ctrl_b && i_wdata[PDBIST_START_BIT]
      && !i_wdata[PDBIST_TXRST_BIT]; // RULE_16 RULE_17

   // only a 0 to 1 change of the enable rearms the receiver
   assign rx_enable_rise = wr_ctrl_a && i_wdata[PDBIST_RX_EN_BIT]
      && !test_receive_enable; // RULE_23 RULE_01

   // self_test_control_a storage
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         test_receive_enable <= 1'b0;
         self_test_enable <= 1'b0;
         test_pattern_mode <= PDBIST_MODE_RESET; // RULE_07
      end else if (wr_ctrl_a) begin
         test_receive_enable <= i_wdata[PDBIST_RX_EN_BIT];
         self_test_enable <= i_wdata[PDBIST_EN_BIT];
         test_pattern_mode <= i_wdata[PDBIST_MODE_MSB:0];
      end
   end

   // transmitter power follows the enable bit directly
   assign o_tx_power_up = self_test_enable; // RULE_05

   // loopback under self-test fences off the functional receive path
   assign o_functional_rx_valid = i_rx_data_valid
      && !(self_test_enable && i_loopback_enable); // RULE_03
   // the same fence hides hard reset signalling from the mac
   assign o_hard_reset_detected = i_hard_reset_seen
      && !(self_test_enable && i_loopback_enable); // RULE_04

   // bit timer: one tick per nominal bit period while sending
   assign bit_end = (bit_timer == PDBIST_BIT_LAST);

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bit_timer <= '0;
      end else if (tx_reset_pulse || (tx_state == PDBIST_TX_IDLE)) begin
         bit_timer <= '0;
      end else if (bit_end) begin
         bit_timer <= '0;
      end else begin
         bit_timer <= bit_timer + 10'h001;
      end
   end

   // transmitter next state; reset has priority over everything else
   always_comb begin
      next_tx_state = tx_state;
      case (tx_state)
         PDBIST_TX_IDLE: begin
            // the carrier pattern runs free, any other mode sends one frame
            if (tx_start_pulse && self_test_enable) begin
               if (test_pattern_mode == PDBIST_MODE_CARRIER2) begin
                  next_tx_state = PDBIST_TX_CARRIER; // RULE_19
               end else begin
                  next_tx_state = PDBIST_TX_FRAME; // RULE_19
               end
            end
         end
         PDBIST_TX_CARRIER: begin
            next_tx_state = PDBIST_TX_CARRIER;
         end
         PDBIST_TX_FRAME: begin
            // one frame only; a new start is needed for the next
            if (bit_end && (frame_bits == PDBIST_FRAME_LAST)) begin
               next_tx_state = PDBIST_TX_IDLE;
            end
         end
         default: begin
            next_tx_state = PDBIST_TX_IDLE;
         end
      endcase
      if (tx_reset_pulse) begin
         next_tx_state = PDBIST_TX_IDLE; // RULE_14 RULE_16
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tx_state <= PDBIST_TX_IDLE;
      end else begin
         tx_state <= next_tx_state;
      end
   end

   // busy flag seen by software and the encoder
   assign o_tx_active = (tx_state != PDBIST_TX_IDLE); // RULE_18

   // frame bit counter; cleared by reset and by each fresh start
   // a start while busy is ignored, so it must not stretch the frame
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         frame_bits <= '0;
      end else if (tx_reset_pulse || (tx_start_pulse && !o_tx_active)) begin
         frame_bits <= '0;
      end else if ((tx_state == PDBIST_TX_FRAME) && bit_end) begin
         frame_bits <= frame_bits + 11'h001;
      end
   end

   // steps as each frame bit loads, not at the closing edge,
   // so frames chain without losing a value
   assign tx_prbs_step = ((tx_state == PDBIST_TX_IDLE) && tx_start_pulse
      && self_test_enable && (test_pattern_mode != PDBIST_MODE_CARRIER2))
      || ((tx_state == PDBIST_TX_FRAME) && bit_end
      && (frame_bits != PDBIST_FRAME_LAST)); // RULE_13

   // only transmit reset reloads the generator, so frames chain the sequence
   pdbist_prbs u_tx_prbs (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_load(tx_reset_pulse), // RULE_10 RULE_13
      .i_step(tx_prbs_step),
      .o_bit(tx_prbs_bit)
   );

   // test bit output: carrier toggles each bit, frame takes the prbs
   // value as it stands before the generator steps
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_tx_bit <= 1'b0;
      end else if (tx_reset_pulse) begin
         o_tx_bit <= 1'b0;
      end else if ((tx_state == PDBIST_TX_IDLE) && tx_start_pulse) begin
         o_tx_bit <= (test_pattern_mode == PDBIST_MODE_CARRIER2) ? 1'b0 : tx_prbs_bit;
      end else if ((tx_state == PDBIST_TX_CARRIER) && bit_end) begin
         o_tx_bit <= !o_tx_bit; // alternating ones and zeros
      end else if (tx_prbs_step) begin
         o_tx_bit <= tx_prbs_bit;
      end
   end

   // strobe marks the first bit and each later bit boundary
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_tx_bit_strobe <= 1'b0;
      end else begin
         o_tx_bit_strobe <= (next_tx_state != PDBIST_TX_IDLE)
            && (((tx_state == PDBIST_TX_IDLE) && tx_start_pulse) || (o_tx_active && bit_end));
      end
   end

   // receive checker: compare each received bit with the local sequence
   assign rx_bit_take = test_receive_enable && i_rx_bit_valid && !rx_enable_rise;
   assign rx_mismatch = rx_bit_take && (i_rx_bit != chk_prbs_bit); // RULE_26
   assign rx_frame_done = test_receive_enable && i_rx_frame_end && !rx_enable_rise;

   pdbist_prbs u_chk_prbs (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_load(rx_enable_rise), // RULE_23
      .i_step(rx_bit_take),
      .o_bit(chk_prbs_bit)
   );

   // the counter is cleared by software or by rearming the receiver
   pdbist_err_count u_err_count (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_clear(clear_count_pulse || rx_enable_rise), // RULE_09 RULE_23
      .i_inc(rx_mismatch), // RULE_26
      .o_count(test_error_count)
   );

   // per-frame error memory, restarted at every frame end
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         frame_had_error <= 1'b0;
      end else if (rx_enable_rise || rx_frame_done) begin
         frame_had_error <= 1'b0;
      end else if (rx_mismatch) begin
         frame_had_error <= 1'b1;
      end
   end

   // done flag: hardware set beats a software clear in the same cycle
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         test_frame_received_flag <= 1'b0;
      end else if (rx_frame_done) begin
         test_frame_received_flag <= 1'b1; // RULE_25
      end else if (wr_rx_stat && i_wdata[PDBIST_RX_DONE_BIT]) begin
         test_frame_received_flag <= 1'b0; // RULE_25
      end
   end

   // error flag is only meaningful while the done flag is set
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         test_frame_error_flag <= 1'b0;
      end else if (rx_enable_rise) begin
         test_frame_error_flag <= 1'b0;
      end else if (rx_frame_done) begin
         test_frame_error_flag <= frame_had_error || rx_mismatch; // RULE_25
      end
   end

   // automatic error count report after each test frame
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_send_error_count_msg <= 1'b0;
      end else begin
         o_send_error_count_msg <= rx_frame_done && i_automatic_response_enable; // RULE_21
      end
   end

   // read mux; unmapped addresses and write-only bits read zero
   always_comb begin
      next_rdata = PDBIST_BYTE_RESET;
      case (i_addr)
         PDBIST_CTRL_A_ADDR: begin
            next_rdata[PDBIST_RX_EN_BIT] = test_receive_enable;
            next_rdata[PDBIST_EN_BIT] = self_test_enable;
            next_rdata[PDBIST_MODE_MSB:0] = test_pattern_mode;
         end
         PDBIST_CTRL_B_ADDR: begin
            next_rdata[PDBIST_START_BIT] = o_tx_active; // RULE_18 RULE_12
         end
         PDBIST_ERR_HI_ADDR: begin
            next_rdata = test_error_count[15:8]; // RULE_22
         end
         PDBIST_ERR_LO_ADDR: begin
            next_rdata = test_error_count[7:0]; // RULE_24
         end
         PDBIST_RX_STAT_ADDR: begin
            next_rdata[PDBIST_RX_DONE_BIT] = test_frame_received_flag;
            next_rdata[PDBIST_RX_ERR_BIT] = test_frame_error_flag;
         end
         default: begin
            next_rdata = PDBIST_BYTE_RESET;
         end
      endcase
   end

   // read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata <= PDBIST_BYTE_RESET;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end else begin
         o_rdata <= PDBIST_BYTE_RESET;
      end
   end
endmodule : pdbist_ctrl

// ### pdbist_ctrl_sva.sv
// assertion checker for the pd mac self-test control block
`timescale 1ns/1ps
module pdbist_ctrl_sva
   import pdbist_pkg::*;
(
   input wire logic i_clk, // core clock
   input wire logic i_sys_rst, // async reset
   input wire logic [15:0] i_addr, // address
   input wire logic [7:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   input wire logic [7:0] o_rdata, // read data
   input wire logic i_loopback_enable, // loopback
   input wire logic i_automatic_response_enable, // auto response
   input wire logic i_rx_frame_end, // frame end
   input wire logic i_rx_data_valid, // functional rx in
   input wire logic i_hard_reset_seen, // hard reset in
   input wire logic o_functional_rx_valid, // functional rx out
   input wire logic o_hard_reset_detected, // hard reset out
   input wire logic o_tx_power_up, // tx power
   input wire logic o_tx_active, // tx busy
   input wire logic o_tx_bit_strobe, // bit strobe
   input wire logic o_send_error_count_msg // message pulse
);
   logic [2:0] mode_q;
   logic blk, wr_a, wr_b;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   // register writes
   assign wr_a = i_wr && i_addr == PDBIST_CTRL_A_ADDR;
   assign wr_b = i_wr && i_addr == PDBIST_CTRL_B_ADDR;
   // shadow of the pattern field
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_q <= PDBIST_MODE_RESET;
      end else if (wr_a) begin
         mode_q <= i_wdata[2:0];
      end
   end
   // power-up mirrors the enable bit
   assign blk = o_tx_power_up & i_loopback_enable;
   property p_power;
      wr_a |=> o_tx_power_up == $past(i_wdata[3]);
   endproperty
   a_power: assert property (p_power) else $error("tx power not following enable");
   property p_func;
      o_functional_rx_valid == (i_rx_data_valid & !blk);
   endproperty
   a_func: assert property (p_func) else $error("functional rx gating wrong");
   property p_hard;
      o_hard_reset_detected == (i_hard_reset_seen & !blk);
   endproperty
   a_hard: assert property (p_hard) else $error("hard reset gating wrong");
   property p_txrst;
      wr_b && i_wdata[1] |=> !o_tx_active && !o_tx_bit_strobe;
   endproperty
   a_txrst: assert property (p_txrst) else $error("tx not idle after reset");
   property p_start;
      wr_b && i_wdata[1:0] == 2'h1 && o_tx_power_up && !o_tx_active |=> o_tx_active && o_tx_bit_strobe;
   endproperty
   a_start: assert property (p_start) else $error("start did not begin sending");
   property p_status;
      i_rd && i_addr == PDBIST_CTRL_B_ADDR |=> o_rdata == {7'h00, $past(o_tx_active)};
   endproperty
   a_status: assert property (p_status) else $error("control b read wrong");
   property p_mode;
      i_rd && i_addr == PDBIST_CTRL_A_ADDR |=> o_rdata[2:0] == $past(mode_q);
   endproperty
   a_mode: assert property (p_mode) else $error("pattern mode read wrong");
   property p_msg;
      o_send_error_count_msg |-> $past(i_rx_frame_end) && $past(i_automatic_response_enable);
   endproperty
   a_msg: assert property (p_msg) else $error("unexpected count message");
   property p_clear;
      (wr_b && i_wdata[2]) ##1 (i_rd && i_addr == PDBIST_ERR_LO_ADDR) |=> o_rdata == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("count not cleared");
   c_start: cover property (o_tx_active && o_tx_bit_strobe);
   c_msg: cover property (o_send_error_count_msg);
   c_block: cover property (blk && i_rx_data_valid);
endmodule : pdbist_ctrl_sva

bind pdbist_ctrl pdbist_ctrl_sva i_sva (
   .i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_loopback_enable,
   .i_automatic_response_enable, .i_rx_frame_end, .i_rx_data_valid, .i_hard_reset_seen,
   .o_functional_rx_valid, .o_hard_reset_detected, .o_tx_power_up, .o_tx_active,
   .o_tx_bit_strobe, .o_send_error_count_msg
);

// ### pdbist_link_model.sv
// loopback receiver model: returns each test bit as a decoded receive bit
`timescale 1ns/1ps
module pdbist_link_model (
   input wire logic i_clk, // core clock
   input wire logic i_sys_rst, // async reset
   input wire logic i_tx_bit, // test bit out
   input wire logic i_tx_bit_strobe, // new test bit
   input wire logic i_corrupt, // flip returned bits
   output logic o_rx_bit, // decoded bit back
   output logic o_rx_bit_valid // one pulse per bit
);
   // one cycle decode delay; data wanders between pulses to expose late sampling
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rx_bit <= 1'b0;
         o_rx_bit_valid <= 1'b0;
      end else if (i_tx_bit_strobe) begin
         o_rx_bit <= i_tx_bit ^ i_corrupt;
         o_rx_bit_valid <= 1'b1;
      end else begin
         o_rx_bit <= ~o_rx_bit;
         o_rx_bit_valid <= 1'b0;
      end
   end
endmodule : pdbist_link_model

// ### pdbist_ctrl_tb.sv
// self-checking testbench for the pd mac self-test control block
`timescale 1ns/1ps
module pdbist_ctrl_tb
   import pdbist_pkg::*;
;
   logic i_clk, i_sys_rst, i_wr, i_rd, i_loopback_enable, i_automatic_response_enable;
   logic i_rx_frame_end, i_rx_data_valid, i_hard_reset_seen, corrupt, i_rx_bit, i_rx_bit_valid;
   logic [15:0] i_addr;
   logic [7:0] i_wdata, o_rdata;
   logic o_functional_rx_valid, o_hard_reset_detected, o_tx_power_up, o_tx_active;
   logic o_tx_bit, o_tx_bit_strobe, o_send_error_count_msg, b;
   logic [14:0] lf;
   int n_errors = 0;
   int checked = 0;

   pdbist_ctrl i_dut (
      .i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_loopback_enable,
      .i_automatic_response_enable, .i_rx_bit, .i_rx_bit_valid, .i_rx_frame_end,
      .i_rx_data_valid, .i_hard_reset_seen, .o_functional_rx_valid, .o_hard_reset_detected,
      .o_tx_power_up, .o_tx_active, .o_tx_bit, .o_tx_bit_strobe, .o_send_error_count_msg
   );
   pdbist_link_model i_link (
      .i_clk, .i_sys_rst, .i_tx_bit(o_tx_bit),
      .i_tx_bit_strobe(o_tx_bit_strobe), .i_corrupt(corrupt),
      .o_rx_bit(i_rx_bit), .o_rx_bit_valid(i_rx_bit_valid)
   );

   // 200 MHz core clock
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   task automatic complete_run();
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [7:0] s, e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %0t: seen %h, expected %h", $time, s, e);
      end
   endtask : chk

   // one-cycle write; strobe dropped at the taking edge
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the read edge
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, e);
   endtask : rd

   // bounded wait for the next bit strobe, a bit lasts about 666 cycles
   task automatic wstb();
      int k;
      k = 0;
      do begin
         @(negedge i_clk);
         k++;
      end while (o_tx_bit_strobe !== 1'b1 && k < 700);
      if (o_tx_bit_strobe !== 1'b1) begin
         n_errors++;
         $display("ERROR %0t: no bit strobe", $time);
         complete_run();
      end
   endtask : wstb

   task automatic t_reset_values();
      rd(PDBIST_CTRL_A_ADDR, 8'h00);
      rd(PDBIST_CTRL_B_ADDR, 8'h00);
      rd(PDBIST_ERR_LO_ADDR, 8'h00);
      rd(PDBIST_RX_STAT_ADDR, 8'h00);
      wr(PDBIST_ERR_HI_ADDR, 8'hFF);
      rd(PDBIST_ERR_HI_ADDR, 8'h00);
      wr(16'h1AC4, 8'hFF);
      rd(16'h1AC4, 8'h00);
   endtask : t_reset_values

   task automatic t_gating();
      wr(PDBIST_CTRL_A_ADDR, 8'h0A);
      rd(PDBIST_CTRL_A_ADDR, 8'h0A);
      chk({7'h00, o_tx_power_up}, 8'h01);
      @(posedge i_clk);
      {i_loopback_enable, i_rx_data_valid, i_hard_reset_seen} <= 3'h7;
      @(negedge i_clk);
      chk({7'h00, o_functional_rx_valid}, 8'h00);
      chk({7'h00, o_hard_reset_detected}, 8'h00);
      wr(PDBIST_CTRL_A_ADDR, 8'h02);
      @(negedge i_clk);
      chk({7'h00, o_tx_power_up}, 8'h00);
      chk({7'h00, o_functional_rx_valid}, 8'h01);
      @(posedge i_clk);
      {i_loopback_enable, i_rx_data_valid, i_hard_reset_seen} <= 3'h0;
   endtask : t_gating

   task automatic t_carrier();
      wr(PDBIST_CTRL_A_ADDR, 8'h0A);
      repeat (1000) @(posedge i_clk);
      wr(PDBIST_CTRL_B_ADDR, 8'h03);
      @(negedge i_clk);
      chk({7'h00, o_tx_active}, 8'h00);
      wr(PDBIST_CTRL_B_ADDR, 8'h02);
      wr(PDBIST_CTRL_B_ADDR, 8'h01);
      @(negedge i_clk);
      chk({7'h00, o_tx_active}, 8'h01);
      rd(PDBIST_CTRL_B_ADDR, 8'h01);
      wstb();
      b = o_tx_bit;
      wstb();
      chk({7'h00, o_tx_bit}, {7'h00, ~b});
      wr(PDBIST_CTRL_B_ADDR, 8'h02);
      @(negedge i_clk);
      chk({7'h00, o_tx_active}, 8'h00);
      rd(PDBIST_CTRL_B_ADDR, 8'h00);
   endtask : t_carrier

   // prbs frame looped back, bits 3 to 15 spoiled on the way
   task automatic t_frame();
      repeat (700) @(posedge i_clk);
      wr(PDBIST_CTRL_A_ADDR, 8'h18);
      @(posedge i_clk);
      i_loopback_enable <= 1'b1;
      i_automatic_response_enable <= 1'b1;
      wr(PDBIST_CTRL_B_ADDR, 8'h02);
      lf = PDBIST_PRBS_SEED;
      wr(PDBIST_CTRL_B_ADDR, 8'h01);
      for (int i = 0; i < 16; i++) begin
         wstb();
         chk({7'h00, o_tx_bit}, {7'h00, lf[14]});
         lf = {lf[13:0], lf[14] ^ lf[13]};
         @(posedge i_clk);
         corrupt <= (i >= 2);
      end
      wr(PDBIST_CTRL_B_ADDR, 8'h02);
      corrupt <= 1'b0;
      rd(PDBIST_ERR_LO_ADDR, 8'h0D);
      rd(PDBIST_ERR_HI_ADDR, 8'h00);
      @(posedge i_clk);
      i_rx_frame_end <= 1'b1;
      @(posedge i_clk);
      i_rx_frame_end <= 1'b0;
      @(negedge i_clk);
      chk({7'h00, o_send_error_count_msg}, 8'h01);
      rd(PDBIST_RX_STAT_ADDR, 8'h03);
      wr(PDBIST_RX_STAT_ADDR, 8'h01);
      rd(PDBIST_RX_STAT_ADDR, 8'h02);
      // clear then read straight behind it
      @(posedge i_clk);
      i_addr <= PDBIST_CTRL_B_ADDR;
      i_wdata <= 8'h04;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_addr <= PDBIST_ERR_LO_ADDR;
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, 8'h00);
   endtask : t_frame

   initial begin
      i_sys_rst = 1'b1;
      {i_addr, i_wdata, i_wr, i_rd, i_loopback_enable, i_automatic_response_enable} = '0;
      {i_rx_frame_end, i_rx_data_valid, i_hard_reset_seen, corrupt} = '0;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_reset_values();
      t_gating();
      t_carrier();
      t_frame();
      complete_run();
   end
endmodule : pdbist_ctrl_tb
